// File: src/sbrf_framer.sv
`timescale 1ns/1ps
// Function
// - accept every MAC address query without error, answer with type 0xD8
// - response and reason codes sit in bytes 16 to 19
// - address count in the top byte of bytes 20 to 23, byte 20
// - reserved field beside count driven zero, receiver ignores it
// - each address sent byte 5 first down to byte 0, packed without gaps
// - odd count appends two zero pad bytes, even count none
// - UUID query 0x52 is package-wide, always answered with 0xD2
// - UUID in bytes 20 to 35, checksum 36 to 39, pad 40 to 45
// - multi-byte UUID fields go most significant byte first
// - time-based UUID version preferred; other versions allowed
// - time-based layout: time low, mid, high+version, clock seq, node
// - link event: type 0x00, link state, vendor state, checksum
// - link event sent whenever the actual link mode changes
// - config-required event type 0x01 on initial state, not after channel reset
// - config-required event may be skipped on some hardware resets
// - driver event type 0x02, status word then checksum
// - status bit 0 is driver running, bits 1 to 31 zero
// - MAC query 0x58 is per channel; controller asks each channel
module sbrf_framer
    import sbrf_pkg::*;
#(
    parameter int MAX_ADDR = 4
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic cmd_valid_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic [127:0] hdr_i,
    input wire logic [15:0] rsp_code_i,
    input wire logic [15:0] reason_code_i,
    input wire logic [7:0] addr_count_i,
    input wire logic [MAX_ADDR*48-1:0] mac_addrs_i,
    input wire logic [127:0] uuid_i,
    input wire logic [31:0] link_state_i,
    input wire logic [31:0] vendor_link_state_word_i,
    input wire logic enter_initial_i,
    input wire logic by_channel_reset_i,
    input wire logic hw_reset_skip_i,
    input wire logic driver_running_i,
    input wire logic out_ready_i,
    output logic out_valid_o,
    output logic [7:0] out_data_o,
    output logic out_sop_o,
    output logic out_eop_o,
    output logic busy_o
);
    // ----------------------------------------
    // event capture
    // ----------------------------------------
    logic [31:0] link_prev_reg;
    logic drv_prev_reg;
    logic link_pend_reg;
    logic cfg_pend_reg;
    logic drv_pend_reg;
    logic mac_pend_reg;
    logic uuid_pend_reg;
    logic started_reg;
    sbrf_state_e state_reg;
    sbrf_kind_e kind_reg;
    logic [7:0] idx_reg;
    logic [7:0] body_len_reg;
    logic [15:0] sum_reg;
    logic [7:0] cur_byte;
    logic start;
    sbrf_kind_e start_kind;

    // change detectors, first cycle after reset only records state
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            link_prev_reg <= '0;
            drv_prev_reg <= 1'b0;
            started_reg <= 1'b0;
        end else begin
            link_prev_reg <= link_state_i;
            drv_prev_reg <= driver_running_i;
            started_reg <= 1'b1;
        end
    end

    // pending flags; a new event wins over the clear of a launch
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            link_pend_reg <= 1'b0;
            cfg_pend_reg <= 1'b0;
            drv_pend_reg <= 1'b0;
            mac_pend_reg <= 1'b0;
            uuid_pend_reg <= 1'b0;
        end else begin
            if (start && start_kind == SBRF_K_LINK) link_pend_reg <= 1'b0;
            if (start && start_kind == SBRF_K_CFG) cfg_pend_reg <= 1'b0;
            if (start && start_kind == SBRF_K_DRV) drv_pend_reg <= 1'b0;
            if (start && start_kind == SBRF_K_MAC) mac_pend_reg <= 1'b0;
            if (start && start_kind == SBRF_K_UUID) uuid_pend_reg <= 1'b0;
            if (started_reg && link_state_i != link_prev_reg) link_pend_reg <= 1'b1;
            if (enter_initial_i && !by_channel_reset_i && !hw_reset_skip_i) begin
                cfg_pend_reg <= 1'b1;
            end
            if (started_reg && driver_running_i != drv_prev_reg) drv_pend_reg <= 1'b1;
            if (cmd_valid_i && cmd_code_i == SBRF_CMD_MAC_ADDR) mac_pend_reg <= 1'b1;
            if (cmd_valid_i && cmd_code_i == SBRF_CMD_UUID) uuid_pend_reg <= 1'b1;
        end
    end

    // ----------------------------------------
    // packet selection
    // ----------------------------------------
    always_comb begin
        start = (state_reg == SBRF_ST_IDLE) &&
                (mac_pend_reg || uuid_pend_reg || link_pend_reg || cfg_pend_reg || drv_pend_reg);
        if (mac_pend_reg) start_kind = SBRF_K_MAC;
        else if (uuid_pend_reg) start_kind = SBRF_K_UUID;
        else if (link_pend_reg) start_kind = SBRF_K_LINK;
        else if (cfg_pend_reg) start_kind = SBRF_K_CFG;
        else start_kind = SBRF_K_DRV;
    end

    // body bytes after the 16 byte header, before pad and checksum
    function automatic logic [7:0] body_len(input sbrf_kind_e k, input logic [7:0] n);
        logic [7:0] cnt;
        cnt = (n > 8'(MAX_ADDR)) ? 8'(MAX_ADDR) : n;
        unique case (k)
            SBRF_K_MAC: body_len = 8'(8 + SBRF_MAC_BYTES * int'(cnt));
            SBRF_K_UUID: body_len = 8'(4 + SBRF_UUID_BYTES);
            SBRF_K_LINK: body_len = 8'd12;
            SBRF_K_CFG: body_len = 8'd4;
            SBRF_K_DRV: body_len = 8'd8;
        endcase
    endfunction

    // ----------------------------------------
    // byte generator
    // ----------------------------------------
    always_comb begin
        int b;
        int a;
        int j;
        b = 0;
        a = 0;
        j = 0;
        cur_byte = SBRF_PAD_BYTE;
        unique case (state_reg)
            SBRF_ST_HDR: cur_byte = hdr_i[127 - 8*int'(idx_reg) -: 8];
            SBRF_ST_BODY: begin
                b = int'(idx_reg);
                if (kind_reg == SBRF_K_MAC || kind_reg == SBRF_K_UUID) begin
                    if (b < 2) cur_byte = rsp_code_i[15 - 8*b -: 8];
                    else if (b < 4) cur_byte = reason_code_i[15 - 8*(b-2) -: 8];
                    else if (kind_reg == SBRF_K_UUID) begin
                        cur_byte = uuid_i[127 - 8*(b-4) -: 8];
                    end else if (b == 4) cur_byte = addr_count_i;
                    else if (b < 8) cur_byte = 8'h00;
                    else begin
                        a = (b - 8) / SBRF_MAC_BYTES;
                        j = (b - 8) % SBRF_MAC_BYTES;
                        cur_byte = mac_addrs_i[a*48 + 47 - 8*j -: 8];
                    end
                end else if (kind_reg == SBRF_K_LINK) begin
                    if (b == 3) cur_byte = SBRF_EVT_LINK;
                    else if (b >= 4 && b < 8) cur_byte = link_prev_reg[31 - 8*(b-4) -: 8];
                    else if (b >= 8) cur_byte = vendor_link_state_word_i[31 - 8*(b-8) -: 8];
                end else if (kind_reg == SBRF_K_CFG) begin
                    if (b == 3) cur_byte = SBRF_EVT_CFG_REQ;
                end else begin
                    if (b == 3) cur_byte = SBRF_EVT_DRV;
                    else if (b == 7) cur_byte = {7'h00, drv_prev_reg};
                end
            end
            SBRF_ST_PAD: cur_byte = SBRF_PAD_BYTE;
            SBRF_ST_CSUM: begin
                // ones complement of 16-bit word sum, as a 32-bit field
                if (idx_reg < 8'd2) cur_byte = 8'h00;
                else if (idx_reg == 8'd2) cur_byte = ~sum_reg[15:8];
                else cur_byte = ~sum_reg[7:0];
            end
            SBRF_ST_TPAD: cur_byte = SBRF_PAD_BYTE;
            default: cur_byte = SBRF_PAD_BYTE;
        endcase
    end

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            state_reg <= SBRF_ST_IDLE;
            kind_reg <= SBRF_K_MAC;
            idx_reg <= 8'h00;
            body_len_reg <= 8'h00;
        end else if (start) begin
            state_reg <= SBRF_ST_HDR;
            kind_reg <= start_kind;
            idx_reg <= 8'h00;
            body_len_reg <= body_len(start_kind, addr_count_i);
        end else if (state_reg != SBRF_ST_IDLE && (!out_valid_o || out_ready_i)) begin
            idx_reg <= idx_reg + 8'h01;
            unique case (state_reg)
                SBRF_ST_HDR: if (idx_reg == 8'(SBRF_HDR_BYTES - 1)) begin
                    state_reg <= SBRF_ST_BODY;
                    idx_reg <= 8'h00;
                end
                SBRF_ST_BODY: if (idx_reg == body_len_reg - 8'h01) begin
                    idx_reg <= 8'h00;
                    // odd address count leaves a half word
                    if (kind_reg == SBRF_K_MAC && body_len_reg[1:0] != 2'h0) begin
                        state_reg <= SBRF_ST_PAD;
                    end else begin
                        state_reg <= SBRF_ST_CSUM;
                    end
                end
                SBRF_ST_PAD: if (idx_reg == 8'(SBRF_PAD_ODD - 1)) begin
                    state_reg <= SBRF_ST_CSUM;
                    idx_reg <= 8'h00;
                end
                SBRF_ST_CSUM: if (idx_reg == 8'(SBRF_CSUM_BYTES - 1)) begin
                    idx_reg <= 8'h00;
                    state_reg <= (kind_reg == SBRF_K_UUID) ? SBRF_ST_TPAD : SBRF_ST_IDLE;
                end
                SBRF_ST_TPAD: if (idx_reg == 8'(SBRF_UUID_TAIL_PAD - 1)) begin
                    state_reg <= SBRF_ST_IDLE;
                end
                default: state_reg <= SBRF_ST_IDLE;
            endcase
        end
    end

    // running 16-bit checksum over header, payload and pad
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || start) begin
            sum_reg <= 16'h0000;
        end else if (state_reg inside {SBRF_ST_HDR, SBRF_ST_BODY, SBRF_ST_PAD} &&
                     (!out_valid_o || out_ready_i)) begin
            sum_reg <= sum_reg + (idx_reg[0] ? {8'h00, cur_byte} : {cur_byte, 8'h00});
        end
    end

    // ----------------------------------------
    // registered output stage
    // ----------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            out_valid_o <= 1'b0;
            out_data_o <= 8'h00;
            out_sop_o <= 1'b0;
            out_eop_o <= 1'b0;
            busy_o <= 1'b0;
        end else begin
            busy_o <= (state_reg != SBRF_ST_IDLE) || start;
            if (!out_valid_o || out_ready_i) begin
                out_valid_o <= state_reg != SBRF_ST_IDLE;
                out_data_o <= cur_byte;
                out_sop_o <= state_reg == SBRF_ST_HDR && idx_reg == 8'h00;
                out_eop_o <= (state_reg == SBRF_ST_TPAD &&
                              idx_reg == 8'(SBRF_UUID_TAIL_PAD - 1)) ||
                             (state_reg == SBRF_ST_CSUM && kind_reg != SBRF_K_UUID &&
                              idx_reg[1:0] == SBRF_WORD_LANE_LAST);
            end
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    AST_MAC_ACCEPT: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        cmd_valid_i && cmd_code_i == SBRF_CMD_MAC_ADDR |=> mac_pend_reg || state_reg != SBRF_ST_IDLE)
        else $error("mac query not latched");
    AST_UUID_ACCEPT: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        cmd_valid_i && cmd_code_i == SBRF_CMD_UUID |=> uuid_pend_reg || state_reg != SBRF_ST_IDLE)
        else $error("uuid query not latched");
    // pad bytes reach the output register as zero
    AST_PAD_ZERO: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        state_reg == SBRF_ST_PAD && (!out_valid_o || out_ready_i)
        |=> out_valid_o && out_data_o == SBRF_PAD_BYTE)
        else $error("pad byte not zero");
    // events and even-count responses never carry the odd-count pad
    AST_PAD_MAC_ONLY: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        state_reg == SBRF_ST_PAD |-> kind_reg == SBRF_K_MAC && body_len_reg[1:0] != 2'h0)
        else $error("pad outside odd address response");
    AST_CFG_SUPPRESS: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        enter_initial_i && by_channel_reset_i && !cfg_pend_reg |=> !cfg_pend_reg)
        else $error("config event after channel reset");
    AST_LINK_EVENT: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        started_reg && link_state_i != link_prev_reg |=> link_pend_reg || state_reg != SBRF_ST_IDLE)
        else $error("link change missed");
    AST_PAD_TO_CSUM: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        state_reg == SBRF_ST_PAD && out_ready_i ##1 state_reg == SBRF_ST_PAD && out_ready_i
        |=> state_reg == SBRF_ST_CSUM)
        else $error("checksum does not follow pad");
    AST_RSV_ZERO: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        state_reg == SBRF_ST_BODY && kind_reg == SBRF_K_MAC && idx_reg inside {[5:7]} &&
        (!out_valid_o || out_ready_i) |=> out_data_o == 8'h00)
        else $error("reserved byte not zero");
    AST_DRV_BIT: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        state_reg == SBRF_ST_BODY && kind_reg == SBRF_K_DRV && idx_reg == 8'd7 &&
        (!out_valid_o || out_ready_i) |=> out_data_o[7:1] == 7'h00)
        else $error("driver status reserved bits set");
    // uuid checksum is followed by the six tail pad bytes, not by the end
    AST_UUID_TAIL: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        state_reg == SBRF_ST_CSUM && kind_reg == SBRF_K_UUID &&
        idx_reg == 8'(SBRF_CSUM_BYTES - 1) && (!out_valid_o || out_ready_i)
        |=> state_reg == SBRF_ST_TPAD && !out_eop_o)
        else $error("uuid tail pad missing");
endmodule

// File: common/sbrf_pkg.sv
package sbrf_pkg;
    // ----------------------------------------
    // packet type and field codes
    // ----------------------------------------
    localparam logic [7:0] SBRF_RSP_MAC_ADDR = 8'hd8;
    localparam logic [7:0] SBRF_CMD_MAC_ADDR = 8'h58;
    localparam logic [7:0] SBRF_CMD_UUID = 8'h52;
    localparam logic [7:0] SBRF_RSP_UUID = 8'hd2;
    localparam logic [7:0] SBRF_EVT_LINK = 8'h00;
    localparam logic [7:0] SBRF_EVT_CFG_REQ = 8'h01;
    localparam logic [7:0] SBRF_EVT_DRV = 8'h02;
    localparam logic [7:0] SBRF_PAD_BYTE = 8'h00;
    localparam logic [3:0] SBRF_UUID_VER_TIME = 4'h1;
    // ----------------------------------------
    // byte layout
    // ----------------------------------------
    localparam int SBRF_HDR_BYTES = 16;
    localparam int SBRF_MAC_BYTES = 6;
    localparam int SBRF_UUID_BYTES = 16;
    localparam int SBRF_PAD_ODD = 2;
    localparam int SBRF_CSUM_BYTES = 4;
    localparam int SBRF_UUID_TAIL_PAD = 6;
    localparam logic [1:0] SBRF_WORD_LANE_LAST = 2'h3;
    typedef enum {
        SBRF_K_MAC, SBRF_K_UUID, SBRF_K_LINK, SBRF_K_CFG, SBRF_K_DRV
    } sbrf_kind_e;
    typedef enum {
        SBRF_ST_IDLE, SBRF_ST_HDR, SBRF_ST_BODY, SBRF_ST_PAD, SBRF_ST_CSUM, SBRF_ST_TPAD
    } sbrf_state_e;
endpackage

// File: sim/sbrf_sink.sv
`timescale 1ns/1ps
// ----------------------------------------
// management controller receive side
// ----------------------------------------
module sbrf_sink (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic slow_i,
    input wire logic valid_i,
    input wire logic [7:0] data_i,
    input wire logic sop_i,
    input wire logic eop_i,
    output logic ready_o,
    output int pkt_count_o
);
    logic [9:0] cur_q[$];
    logic [9:0] pkt_q[$];
    logic [1:0] tick_reg;
    // ready pattern: slow mode accepts one byte in four
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            tick_reg <= 2'h0;
            ready_o <= 1'b0;
        end else begin
            tick_reg <= tick_reg + 2'h1;
            ready_o <= slow_i ? (tick_reg == 2'h0) : 1'b1;
        end
    end
    // collect bytes with their flags; reserved fields kept raw, not interpreted
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            cur_q = {};
            pkt_count_o = 0;
        end else if (valid_i && ready_o) begin
            cur_q.push_back({sop_i, eop_i, data_i});
            if (eop_i) begin
                pkt_q = cur_q;
                cur_q = {};
                pkt_count_o = pkt_count_o + 1;
            end
        end
    end
endmodule

// File: sim/sbrf_framer_tb_top.sv
`timescale 1ns/1ps
module sbrf_framer_tb_top;
    import sbrf_pkg::*;
    localparam int NA = 4;
    logic clk = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, enter_init = 1'b0;
    logic chan_rst = 1'b0, hw_skip = 1'b0, drv_run = 1'b0, slow = 1'b0;
    logic [7:0] cmd_code = 8'h00, addr_count = 8'h01;
    logic [127:0] hdr = 128'hf0e1d2c3b4a5968778695a4b3c2d1e0f;
    logic [127:0] uuid = 128'h00112233445516778899aabbccddeeff;
    logic [15:0] rsp = 16'h0001, reason = 16'h8002;
    logic [NA*48-1:0] macs = 192'h0a1b2c3d4e5f_102030405060_a1a2a3a4a5a6_c0c1c2c3c4c5;
    logic [31:0] link_st = 32'h00000000, vend = 32'h5a5a0ff0;
    logic ready, valid, sop, eop, busy;
    logic [7:0] data;
    int bad_count = 0, num_checks = 0, seen = 0;
    logic [7:0] exp_q[$];
    // clock, 4 ns period
    always #2 clk = ~clk;
    sbrf_framer #(.MAX_ADDR(NA)) sbrf_framer_i (.ref_clk_i(clk), .rst_n_i(rst_n),
        .cmd_valid_i(cmd_valid), .cmd_code_i(cmd_code), .hdr_i(hdr), .rsp_code_i(rsp),
        .reason_code_i(reason), .addr_count_i(addr_count), .mac_addrs_i(macs),
        .uuid_i(uuid), .link_state_i(link_st), .vendor_link_state_word_i(vend),
        .enter_initial_i(enter_init), .by_channel_reset_i(chan_rst),
        .hw_reset_skip_i(hw_skip), .driver_running_i(drv_run), .out_ready_i(ready),
        .out_valid_o(valid), .out_data_o(data), .out_sop_o(sop), .out_eop_o(eop),
        .busy_o(busy));
    sbrf_sink sbrf_sink_i (.clk_i(clk), .rst_n_i(rst_n), .slow_i(slow), .valid_i(valid),
        .data_i(data), .sop_i(sop), .eop_i(eop), .ready_o(ready), .pkt_count_o());
    // ----------------------------------------
    // shared helpers
    // ----------------------------------------
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] want);
        num_checks++;
        if (got !== want) begin
            bad_count++;
            $display("ERROR %0t mismatch seen %h expected %h", $time, got, want);
        end
    endtask
    task automatic add_word(input logic [31:0] w);
        for (int k = 3; k >= 0; k--) exp_q.push_back(w[8*k +: 8]);
    endtask
    // header then the word of bytes 16 to 19
    task automatic start_pkt(input logic [31:0] w);
        exp_q = {};
        for (int k = 0; k < 16; k++) exp_q.push_back(hdr[127-8*k -: 8]);
        add_word(w);
    endtask
    // checksum over everything so far, then trailing pad
    task automatic finish_pkt(input int trail);
        logic [15:0] s;
        s = 16'h0000;
        for (int k = 0; k < exp_q.size(); k += 2) s = s + {exp_q[k], exp_q[k+1]};
        add_word({16'h0000, ~s});
        for (int k = 0; k < trail; k++) exp_q.push_back(SBRF_PAD_BYTE);
    endtask
    // wait for the next whole packet and compare bytes and framing flags
    task automatic expect_pkt();
        int n;
        n = 0;
        while (sbrf_sink_i.pkt_count_o == seen && n < 600) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 600) begin
            check(32'h0, 32'h1);
            print_verdict();
        end
        seen++;
        check(32'(sbrf_sink_i.pkt_q.size()), 32'(exp_q.size()));
        for (int k = 0; k < exp_q.size() && k < sbrf_sink_i.pkt_q.size(); k++)
            check({22'h0, sbrf_sink_i.pkt_q[k]},
                  {22'h0, (k == 0), (k == exp_q.size() - 1), exp_q[k]});
    endtask
    task automatic build_uuid();
        start_pkt({rsp, reason});
        for (int k = 0; k < 16; k++) exp_q.push_back(uuid[127-8*k -: 8]);
        finish_pkt(SBRF_UUID_TAIL_PAD);
    endtask
    task automatic build_link();
        start_pkt({24'h0, SBRF_EVT_LINK});
        add_word(link_st);
        add_word(vend);
        finish_pkt(0);
    endtask
    task automatic build_drv();
        start_pkt({24'h0, SBRF_EVT_DRV});
        add_word({31'h0, drv_run});
        finish_pkt(0);
    endtask
    task automatic send_cmd(input logic [7:0] code);
        @(posedge clk);
        cmd_code <= code;
        cmd_valid <= 1'b1;
        @(posedge clk);
        cmd_valid <= 1'b0;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic mac_scn(input logic [7:0] cnt);
        @(posedge clk);
        addr_count <= cnt;
        send_cmd(SBRF_CMD_MAC_ADDR);
        @(posedge clk);
        #1;
        check(32'(busy), 32'h1);
        start_pkt({rsp, reason});
        add_word({cnt, 24'h0});
        for (int a = 0; a < cnt; a++)
            for (int j = 5; j >= 0; j--) exp_q.push_back(macs[a*48+8*j +: 8]);
        if (cnt[0]) add_word({SBRF_PAD_BYTE, SBRF_PAD_BYTE, 16'h0});
        if (cnt[0]) void'(exp_q.pop_back());
        if (cnt[0]) void'(exp_q.pop_back());
        finish_pkt(0);
        expect_pkt();
    endtask
    task automatic uuid_scn();
        send_cmd(SBRF_CMD_UUID);
        build_uuid();
        expect_pkt();
    endtask
    // the uuid response code 0xD2 sent as a command starts nothing
    task automatic ignore_scn();
        send_cmd(SBRF_RSP_UUID);
        repeat (40) @(posedge clk);
        #1;
        check(32'(sbrf_sink_i.pkt_count_o), 32'(seen));
        check(32'(busy), 32'h0);
    endtask
    task automatic link_scn(input logic [31:0] v);
        @(posedge clk);
        link_st <= v;
        @(posedge clk);
        build_link();
        expect_pkt();
    endtask
    task automatic cfg_scn(input logic cr, input logic hs);
        @(posedge clk);
        chan_rst <= cr;
        hw_skip <= hs;
        enter_init <= 1'b1;
        @(posedge clk);
        enter_init <= 1'b0;
        if (!cr && !hs) begin
            start_pkt({24'h0, SBRF_EVT_CFG_REQ});
            finish_pkt(0);
            expect_pkt();
        end else begin
            repeat (80) @(posedge clk);
            #1;
            check(32'(sbrf_sink_i.pkt_count_o), 32'(seen));
            check(32'(busy), 32'h0);
        end
    endtask
    task automatic drv_scn(input logic v);
        @(posedge clk);
        drv_run <= v;
        @(posedge clk);
        build_drv();
        expect_pkt();
    endtask
    // command and two events raised together come out in priority order
    task automatic order_scn();
        @(posedge clk);
        drv_run <= ~drv_run;
        link_st <= 32'h0000a5c3;
        cmd_code <= SBRF_CMD_UUID;
        cmd_valid <= 1'b1;
        @(posedge clk);
        cmd_valid <= 1'b0;
        build_uuid();
        expect_pkt();
        build_link();
        expect_pkt();
        build_drv();
        expect_pkt();
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        mac_scn(8'h01);
        mac_scn(8'h02);
        slow <= 1'b1;
        mac_scn(8'h04);
        uuid_scn();
        ignore_scn();
        slow <= 1'b0;
        link_scn(32'h8000_0021);
        cfg_scn(1'b0, 1'b0);
        cfg_scn(1'b1, 1'b0);
        cfg_scn(1'b0, 1'b1);
        drv_scn(1'b1);
        drv_scn(1'b0);
        slow <= 1'b1;
        order_scn();
        print_verdict();
    end
endmodule
